//--- e1_maintenance.sv
// How it works
// - default standard: alarm set after two low-zero 512-bit blocks, cleared after two.
// - alternate standard: alarm follows each single 512-bit block's zero count.
// - detect-standard bit picks criterion, reset 0; alarm shown in status.
// - alarm detection runs only while clock recovery is enabled.
// - patterns timed by transmit clock, or reference clock when selected.
// - pattern 00 sends normal data, or all zeros with reference clock.
// - pattern 01 sends all ones on the chosen timing.
// - pattern 10 sends the pseudo-random sequence, first bit first.
// - sequence is 2^15-1, generated and checked.
// - invert bit inverts sent and expected sequence.
// - sync set at six or fewer errors in 64-bit window.
// - sync changes latch irq status, rise only or any edge.
// - irq output high while status and mask are both one.
// - error select 00 counts sequence errors in 16-bit counter.
// - analog loop feeds transmitted line back to receiver, line still driven.
// - digital loop feeds transmit data to receive decoder, line still driven.
// - remote loop sends recovered receive data to the transmitter.
// - patterns override transmit data during analog or digital loop.
// - flag same-polarity pulses in AMI, repeated violations in HDB3.
// - excess zeros beyond 15 or 80 in AMI, beyond 3 in HDB3.
// - only selected error type counts; code 11 counts violations and zeros.
// - single rail: violation pin high one receive clock period per violation.
// - auto mode moves count to readable register each second, restarts.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module e1_maintenance
  import e1_maint_pkg::*;
#(
  parameter int CNT_WIDTH   = CNT_WIDTH_DEF,
  parameter int REPORT_CYC  = REPORT_CYCLES
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  // axi4-lite write
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  output logic [1:0]             o_bresp,
  // axi4-lite read
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  // system side
  input  wire logic              i_transmit_clock_in,
  input  wire logic              i_transmit_data,
  input  wire logic              i_master_ref_clock,
  output logic                   o_receive_clock_out,
  output logic                   o_receive_data_out,
  output logic                   o_violation_pulse_out,
  // line side
  input  wire logic              i_line_rx_clock,
  input  wire logic              i_line_rx_pos,
  input  wire logic              i_line_rx_neg,
  output logic                   o_line_transmit_pos,
  output logic                   o_line_transmit_neg,
  // interrupt
  output logic                   o_irq
);
  // refuse widths the logic cannot serve
  if (CNT_WIDTH < 2 || CNT_WIDTH > 32) begin : g_bad_width
    $error("counter width out of range");
  end
  if (REPORT_CYC < 2) begin : g_bad_period
    $error("report period too short");
  end

  localparam int NPIN = 6;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= ADDR_ERR_COUNT);
  endfunction

  maint_zero_s    mz_reg;
  maint_one_s     mo_reg;
  maint_six_s     ms_reg;
  logic           irq_sts_reg, irq_mask_reg, irq_edge_reg;
  logic [NPIN-1:0] pin_raw, pin_s1, pin_s2;
  logic [2:0]     clk_prev;
  logic           tclk_rise, mref_rise, rclk_rise;
  logic           loop_local, remote_eff, pat_active, pat_edge, tx_edge;
  logic           tx_edge_q, tx_pat_bit, tx_bit_reg, mark_pol_reg;
  logic           gen_bit, pred_bit, rx_edge, rx_pos, rx_neg, rx_bit;
  logic           rx_cmp, prbs_err, last_pol_reg, last_viol_reg, pulse_seen;
  logic           viol, bpv_evt, exz_evt, err_evt;
  logic [6:0]     zrun_reg, exz_lim, win_cnt_reg, win_cnt_next;
  logic [SYNC_WINDOW-1:0] win_reg;
  logic           sync_reg, sync_prev_reg, sync_evt;
  logic [8:0]     blk_cnt_reg;
  logic [1:0]     zeros_reg, zeros_inc;
  logic           blk_end, blk_low, prev_low_reg, ais_reg;
  logic [CNT_WIDTH-1:0] err_cnt_reg, count_reg;
  logic [31:0]    tmr_reg;
  logic           tick, xfer_prev_reg, xfer;
  logic           aw_full, w_full, do_wr;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]     wr_byte;
  logic           wr_lane;
  logic           wr_zero, wr_one, wr_six, wr_sts, wr_mask, wr_edge;

  // two-stage synchronisers for every outside pin
  assign pin_raw = {i_line_rx_neg, i_line_rx_pos, i_transmit_data,
                    i_line_rx_clock, i_master_ref_clock, i_transmit_clock_in};
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pin_s1   <= '0;
      pin_s2   <= '0;
      clk_prev <= '0;
    end else begin
      pin_s1   <= pin_raw;
      pin_s2   <= pin_s1;
      clk_prev <= pin_s2[2:0];
    end
  end
  assign tclk_rise = pin_s2[0] & ~clk_prev[0];
  assign mref_rise = pin_s2[1] & ~clk_prev[1];
  assign rclk_rise = pin_s2[2] & ~clk_prev[2];

  // loop precedence: analog, then digital, then remote
  assign loop_local = mo_reg.analog_loop_enable | mo_reg.digital_loop_enable;
  assign remote_eff = mo_reg.remote_loop_enable & ~loop_local;

  // transmit timing and pattern choice
  assign pat_active = (mz_reg.pattern_select == PAT_ONES) ||
                      (mz_reg.pattern_select == PAT_PRBS) ||
                      (mz_reg.pattern_select == PAT_NORMAL &&
                       mz_reg.pattern_clock_select);
  assign pat_edge   = mz_reg.pattern_clock_select ? mref_rise : tclk_rise;
  assign tx_edge    = remote_eff ? rclk_rise
                    : (pat_active ? pat_edge : tclk_rise);
  always_comb begin
    unique case (mz_reg.pattern_select)
      PAT_ONES: tx_pat_bit = 1'b1;
      PAT_PRBS: tx_pat_bit = gen_bit ^ mz_reg.sequence_invert;
      PAT_NORMAL: tx_pat_bit = mz_reg.pattern_clock_select ? 1'b0
                             : pin_s2[3];
      default: tx_pat_bit = pin_s2[3];
    endcase
  end

  // generator advances one bit per pattern timing edge
  prbs15_lfsr u_gen (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_step  (pat_edge && mz_reg.pattern_select == PAT_PRBS),
    .i_check (1'b0),
    .i_in    (1'b0),
    .o_bit   (gen_bit)
  );

  // transmit bit and ami line pair; pattern overrides in local loops
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      tx_bit_reg          <= 1'b0;
      mark_pol_reg        <= 1'b0;
      tx_edge_q           <= 1'b0;
      o_line_transmit_pos <= 1'b0;
      o_line_transmit_neg <= 1'b0;
    end else begin
      tx_edge_q <= tx_edge;
      if (tx_edge) begin
        tx_bit_reg <= remote_eff ? (pin_s2[4] | pin_s2[5])
                                 : tx_pat_bit;
        o_line_transmit_pos <= tx_bit_reg & ~mark_pol_reg;
        o_line_transmit_neg <= tx_bit_reg & mark_pol_reg;
        mark_pol_reg        <= mark_pol_reg ^ tx_bit_reg;
      end
    end
  end

  // receive source: line pins, or own transmit pair when looped
  assign rx_edge = loop_local ? tx_edge_q : rclk_rise;
  assign rx_pos  = loop_local ? o_line_transmit_pos : pin_s2[4];
  assign rx_neg  = loop_local ? o_line_transmit_neg : pin_s2[5];
  assign rx_bit  = rx_pos | rx_neg;

  // receive data and clock outputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_receive_data_out  <= 1'b0;
      o_receive_clock_out <= 1'b0;
    end else begin
      if (rx_edge) begin
        o_receive_data_out <= rx_bit;
      end
      o_receive_clock_out <= loop_local
        ? (pat_active && mz_reg.pattern_clock_select ? pin_s2[1] : pin_s2[0])
        : pin_s2[2];
    end
  end

  // line code violations and zero runs
  assign viol    = rx_bit & pulse_seen & (rx_neg == last_pol_reg);
  assign bpv_evt = rx_edge & viol &
                   (~mo_reg.hdb3_mode | (rx_neg == last_viol_reg));
  assign exz_lim = mo_reg.hdb3_mode ? EXZ_HDB3
                 : (ms_reg.zero_run_definition ? EXZ_AMI_ALT : EXZ_AMI_DEF);
  assign exz_evt = rx_edge & ~rx_bit & (zrun_reg == exz_lim);
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      last_pol_reg  <= 1'b0;
      last_viol_reg <= 1'b0;
      pulse_seen    <= 1'b0;
      zrun_reg      <= '0;
    end else if (rx_edge) begin
      if (rx_bit) begin
        pulse_seen   <= 1'b1;
        last_pol_reg <= rx_neg;
        zrun_reg     <= '0;
      end else if (zrun_reg != 7'h7f) begin
        zrun_reg <= zrun_reg + 7'h01;
      end
      if (viol) begin
        last_viol_reg <= rx_neg;
      end
    end
  end

  // violation pin holds one receive period
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_violation_pulse_out <= 1'b0;
    end else if (rx_edge) begin
      o_violation_pulse_out <= mo_reg.single_rail & bpv_evt;
    end
  end

  // sequence checker and 64-bit sliding error window
  assign rx_cmp   = rx_bit ^ mz_reg.sequence_invert;
  assign prbs_err = rx_cmp ^ pred_bit;
  prbs15_lfsr u_chk (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_step  (rx_edge),
    .i_check (1'b1),
    .i_in    (rx_cmp),
    .o_bit   (pred_bit)
  );
  assign win_cnt_next = win_cnt_reg + {6'h00, prbs_err}
                      - {6'h00, win_reg[SYNC_WINDOW-1]};
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      win_reg     <= '0;
      win_cnt_reg <= '0;
      sync_reg    <= 1'b0;
    end else if (rx_edge) begin
      win_reg     <= {win_reg[SYNC_WINDOW-2:0], prbs_err};
      win_cnt_reg <= win_cnt_next;
      sync_reg    <= (win_cnt_next <= SYNC_MAX_ERR);
    end
  end

  // sync change latch; a set wins over a software clear
  assign sync_evt = (sync_reg & ~sync_prev_reg) |
                    (irq_edge_reg & ~sync_reg & sync_prev_reg);
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sync_prev_reg <= 1'b0;
      irq_sts_reg   <= 1'b0;
    end else begin
      sync_prev_reg <= sync_reg;
      if (sync_evt) begin
        irq_sts_reg <= 1'b1;
      end else if (wr_sts && wr_byte[0]) begin
        irq_sts_reg <= 1'b0;
      end
    end
  end
  assign o_irq = irq_sts_reg & irq_mask_reg;

  // alarm detection over 512-bit blocks
  assign zeros_inc = (~rx_bit && zeros_reg != AIS_MIN_ZEROS)
                   ? zeros_reg + 2'h1 : zeros_reg;
  assign blk_end   = rx_edge && blk_cnt_reg == AIS_BLOCK_LAST;
  assign blk_low   = zeros_inc < AIS_MIN_ZEROS;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !mz_reg.cdr_enable) begin
      blk_cnt_reg  <= '0;
      zeros_reg    <= '0;
      prev_low_reg <= 1'b0;
      ais_reg      <= 1'b0;
    end else if (rx_edge) begin
      blk_cnt_reg <= blk_cnt_reg + 9'h001;
      zeros_reg   <= blk_end ? 2'h0 : zeros_inc;
      if (blk_end) begin
        prev_low_reg <= blk_low;
        if (mz_reg.detect_standard_select) begin
          ais_reg <= blk_low;
        end else if (blk_low && prev_low_reg) begin
          ais_reg <= 1'b1;
        end else if (!blk_low && !prev_low_reg) begin
          ais_reg <= 1'b0;
        end
      end
    end
  end

  // error type selection
  always_comb begin
    unique case (ms_reg.error_select)
      ERR_PRBS: err_evt = rx_edge & prbs_err;
      ERR_VIOL: err_evt = bpv_evt;
      ERR_ZERO: err_evt = exz_evt;
      ERR_BOTH: err_evt = bpv_evt | exz_evt;
    endcase
  end

  // one-second timer and report transfer
  assign tick = ms_reg.counter_report_mode &&
                tmr_reg == 32'(REPORT_CYC - 1);
  assign xfer = ms_reg.counter_report_mode ? tick
              : (ms_reg.count_transfer & ~xfer_prev_reg);
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !ms_reg.counter_report_mode) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tick ? 32'h0 : tmr_reg + 32'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      xfer_prev_reg <= 1'b0;
      err_cnt_reg   <= '0;
      count_reg     <= '0;
    end else begin
      xfer_prev_reg <= ms_reg.count_transfer;
      if (xfer) begin
        count_reg   <= err_cnt_reg;
        err_cnt_reg <= {{(CNT_WIDTH-1){1'b0}}, err_evt};
      end else if (err_evt && !(&err_cnt_reg)) begin
        err_cnt_reg <= err_cnt_reg + 1'b1;
      end
    end
  end

  // axi write: address and data taken in either order
  assign o_awready = ~aw_full;
  assign o_wready  = ~w_full;
  assign do_wr     = aw_full & w_full & ~o_bvalid;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      aw_full  <= 1'b0;
      w_full   <= 1'b0;
      wr_addr  <= '0;
      wr_byte  <= '0;
      wr_lane  <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else begin
      if (i_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        wr_addr <= i_awaddr;
      end
      if (i_wvalid && !w_full) begin
        w_full  <= 1'b1;
        wr_byte <= i_wdata[7:0];
        wr_lane <= i_wstrb[0];
      end
      if (do_wr) begin
        aw_full  <= 1'b0;
        w_full   <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end
  assign wr_zero = do_wr & wr_lane & (wr_addr == ADDR_MAINT_ZERO);
  assign wr_one  = do_wr & wr_lane & (wr_addr == ADDR_MAINT_ONE);
  assign wr_six  = do_wr & wr_lane & (wr_addr == ADDR_MAINT_SIX);
  assign wr_sts  = do_wr & wr_lane & (wr_addr == ADDR_IRQ_STATUS);
  assign wr_mask = do_wr & wr_lane & (wr_addr == ADDR_IRQ_MASK);
  assign wr_edge = do_wr & wr_lane & (wr_addr == ADDR_IRQ_EDGE);

  // control registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      mz_reg       <= MAINT_ZERO_RST;
      mo_reg       <= MAINT_ONE_RST;
      ms_reg       <= MAINT_SIX_RST;
      irq_mask_reg <= 1'b0;
      irq_edge_reg <= 1'b0;
    end else begin
      if (wr_zero) mz_reg <= maint_zero_s'(wr_byte[5:0]);
      if (wr_one)  mo_reg <= maint_one_s'(wr_byte[4:0]);
      if (wr_six)  ms_reg <= maint_six_s'(wr_byte[4:0]);
      if (wr_mask) irq_mask_reg <= wr_byte[0];
      if (wr_edge) irq_edge_reg <= wr_byte[0];
    end
  end

  // axi read: one beat, answer one cycle after address
  assign o_arready = ~o_rvalid;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
      o_rresp  <= RESP_OKAY;
    end else if (i_arvalid && !o_rvalid) begin
      o_rvalid <= 1'b1;
      o_rresp  <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (i_araddr)
        ADDR_MAINT_ZERO:  o_rdata <= {26'h0, mz_reg};
        ADDR_MAINT_ONE:   o_rdata <= {27'h0, mo_reg};
        ADDR_MAINT_SIX:   o_rdata <= {27'h0, ms_reg};
        ADDR_STATUS_ZERO: o_rdata <= {30'h0, sync_reg, ais_reg};
        ADDR_IRQ_STATUS:  o_rdata <= {31'h0, irq_sts_reg};
        ADDR_IRQ_MASK:    o_rdata <= {31'h0, irq_mask_reg};
        ADDR_IRQ_EDGE:    o_rdata <= {31'h0, irq_edge_reg};
        ADDR_ERR_COUNT:   o_rdata <= 32'(count_reg);
        default:          o_rdata <= 32'h0;
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_low_block;
    blk_end && blk_low && mz_reg.cdr_enable;
  endsequence
  AST_AIS_SINGLE: assert property (
    s_low_block and mz_reg.detect_standard_select |=> ais_reg)
    else $error("single low block did not raise alarm");
  AST_AIS_DOUBLE: assert property (
    s_low_block and prev_low_reg |=> ais_reg)
    else $error("two low blocks did not raise alarm");
  AST_AIS_OFF: assert property (!mz_reg.cdr_enable |=> !ais_reg)
    else $error("alarm active with recovery disabled");
  AST_SYNC_WIN: assert property (sync_reg |-> win_cnt_reg <= 7'h06)
    else $error("sync held with too many window errors");
  AST_IRQ_RISE: assert property ($rose(sync_reg) |=> irq_sts_reg)
    else $error("sync rise not latched");
  AST_IRQ_OUT: assert property (
    irq_sts_reg && irq_mask_reg |-> o_irq)
    else $error("interrupt not raised");
  AST_ONES: assert property (
    tx_edge && !remote_eff && mz_reg.pattern_select == PAT_ONES
    |=> tx_bit_reg)
    else $error("all ones pattern not sent");
  AST_ZEROS: assert property (
    tx_edge && !remote_eff && mz_reg.pattern_select == PAT_NORMAL &&
    mz_reg.pattern_clock_select |=> !tx_bit_reg)
    else $error("all zeros pattern not sent");
  AST_CV_PIN: assert property (
    bpv_evt && mo_reg.single_rail |=> o_violation_pulse_out)
    else $error("violation pin not driven");
  AST_COUNT: assert property (
    err_evt && !xfer && !(&err_cnt_reg)
    |=> err_cnt_reg == $past(err_cnt_reg) + 1'b1)
    else $error("error not counted");
endmodule

//--- e1_maint_pkg.sv
// constants and carriers for the e1 maintenance block
package e1_maint_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_MAINT_ZERO  = 8'h00;
  localparam logic [7:0] ADDR_MAINT_ONE   = 8'h04;
  localparam logic [7:0] ADDR_MAINT_SIX   = 8'h08;
  localparam logic [7:0] ADDR_STATUS_ZERO = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EDGE    = 8'h18;
  localparam logic [7:0] ADDR_ERR_COUNT   = 8'h1c;
  localparam int         ADDR_W           = 8;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // maintenance register zero, bits 5..0
  typedef struct packed {
    logic       cdr_enable;
    logic       detect_standard_select;
    logic       sequence_invert;
    logic       pattern_clock_select;
    logic [1:0] pattern_select;
  } maint_zero_s;

  // maintenance register one, bits 4..0
  typedef struct packed {
    logic single_rail;
    logic hdb3_mode;
    logic remote_loop_enable;
    logic digital_loop_enable;
    logic analog_loop_enable;
  } maint_one_s;

  // maintenance register six, bits 4..0
  typedef struct packed {
    logic       count_transfer;
    logic       counter_report_mode;
    logic       zero_run_definition;
    logic [1:0] error_select;
  } maint_six_s;

  // reset values
  localparam maint_zero_s MAINT_ZERO_RST = maint_zero_s'(6'h20);
  localparam maint_one_s  MAINT_ONE_RST  = maint_one_s'(5'h10);
  localparam maint_six_s  MAINT_SIX_RST  = maint_six_s'(5'h00);

  // pattern and error-type codes
  localparam logic [1:0] PAT_NORMAL = 2'h0;
  localparam logic [1:0] PAT_ONES   = 2'h1;
  localparam logic [1:0] PAT_PRBS   = 2'h2;
  localparam logic [1:0] ERR_PRBS   = 2'h0;
  localparam logic [1:0] ERR_VIOL   = 2'h1;
  localparam logic [1:0] ERR_ZERO   = 2'h2;
  localparam logic [1:0] ERR_BOTH   = 2'h3;

  // detection thresholds
  localparam int         AIS_BLOCK_BITS = 512;
  localparam logic [8:0] AIS_BLOCK_LAST = 9'(AIS_BLOCK_BITS - 1);
  localparam logic [1:0] AIS_MIN_ZEROS  = 2'h3;
  localparam int         SYNC_WINDOW    = 64;
  localparam logic [6:0] SYNC_MAX_ERR   = 7'h06;
  localparam logic [6:0] EXZ_AMI_DEF    = 7'h0f;
  localparam logic [6:0] EXZ_AMI_ALT    = 7'h50;
  localparam logic [6:0] EXZ_HDB3       = 7'h03;
  localparam int         PRBS_LEN       = 15;
  localparam int         CNT_WIDTH_DEF  = 16;

  // timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int REPORT_PERIOD_S = 1;
  localparam int REPORT_CYCLES   = CLK_HZ * REPORT_PERIOD_S;
endpackage

//--- prbs15_lfsr.sv
// 2^15-1 sequence register, generator or self-synchronising checker
`timescale 1ns/10ps
module prbs15_lfsr
  import e1_maint_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // control
  input  wire logic i_step,
  input  wire logic i_check,
  input  wire logic i_in,
  // predicted or generated bit
  output logic      o_bit
);
  logic [PRBS_LEN-1:0] state_reg;
  logic                fb;

  // taps x^15 + x^14 + 1
  assign fb    = state_reg[PRBS_LEN-1] ^ state_reg[PRBS_LEN-2];
  assign o_bit = fb;

  // checker shifts in received bits, generator its own output
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_reg <= '1;
    end else if (i_step) begin
      state_reg <= {state_reg[PRBS_LEN-2:0], i_check ? i_in : fb};
    end
  end
endmodule

//--- e1_line_model.sv
// framer and line stand-in with free-running e1 clocks
`timescale 1ns/10ps
module e1_line_model (
  // polarity freeze: every held mark is a violation
  input  logic i_hold,
  // toward the block's clock and line inputs
  output logic o_tclk = 1'b0,
  output logic o_mref = 1'b0,
  output logic o_rclk = 1'b0,
  output logic o_pos  = 1'b0,
  output logic o_neg
);
  // clocks run free; receive phase 130 ns behind transmit
  initial forever #400 o_tclk = ~o_tclk;
  initial forever #244 o_mref = ~o_mref;
  initial #130 forever #400 o_rclk = ~o_rclk;
  // line marks alternate polarity, one per receive bit
  always @(negedge o_rclk) o_pos <= i_hold ? o_pos : ~o_pos;
  assign o_neg = ~o_pos;
endmodule

//--- testbench.sv
// self-checking bench for the e1 maintenance block
`timescale 1ns/10ps
module testbench;
  import e1_maint_pkg::*;
  // block inputs start defined; framer data tied to ones
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_transmit_data = 1'b1;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0;
  logic [ADDR_W-1:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, rdat;
  logic [3:0] i_wstrb = 4'hf;
  logic [1:0] o_bresp, o_rresp, rrsp;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic i_transmit_clock_in, i_master_ref_clock, o_receive_data_out;
  logic i_line_rx_clock, i_line_rx_pos, i_line_rx_neg;
  logic o_receive_clock_out, o_violation_pulse_out;
  logic o_line_transmit_pos, o_line_transmit_neg;
  logic hold_pol = 1'b0;
  int n_fail = 0, samples_checked = 0;
  // 10 mhz block clock
  initial forever #50 i_clk = ~i_clk;
  // block with a short report period, and the far side
  e1_maintenance #(.REPORT_CYC(20)) u_e1_maintenance (.*);
  e1_line_model u_e1_line_model (.i_hold(hold_pol),
    .o_tclk(i_transmit_clock_in),
    .o_mref(i_master_ref_clock), .o_rclk(i_line_rx_clock),
    .o_pos(i_line_rx_pos), .o_neg(i_line_rx_neg));
  // one write (w high) or read, each channel held until taken
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
    logic ta, tw, tr;
    @(posedge i_clk);
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} <= {w, w, w, !w, !w};
    {i_awaddr, i_araddr, i_wdata} <= {a, a, d};
    do begin
      @(negedge i_clk);
      ta = (i_awvalid & o_awready) | (i_arvalid & o_arready);
      tw = i_wvalid & o_wready;
      tr = (i_bready & o_bvalid) | (i_rready & o_rvalid);
      {rdat, rrsp} = {o_rdata, w ? o_bresp : o_rresp};
      @(posedge i_clk);
      if (ta) {i_awvalid, i_arvalid} <= 2'h0;
      if (tw) i_wvalid <= 1'b0;
    end while (tr !== 1'b1);
    {i_bready, i_rready} <= 2'h0;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // read a register and compare the masked bits
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
    xfer(1'b0, a, 32'h0);
    chk(e, rdat & m);
  endtask
  // counts, verdict and end of run
  task automatic test_done(input int extra);
    n_fail += extra;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard, well past the expected 37k cycles
  initial #6_000_000 test_done(1);
  // scenarios
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rchk(8'h00, 32'h3f, 32'h20);
    rchk(8'h04, 32'h1f, 32'h10);
    rchk(8'h24, 32'h0, 32'h0);
    chk(32'(RESP_SLVERR), 32'(rrsp));
    $display("test reset done");
    xfer(1'b1, 8'h04, 32'h13);
    xfer(1'b1, 8'h00, 32'h21);
    repeat (12800) @(posedge i_clk);
    chk(32'h1, 32'(o_receive_data_out));
    @(negedge i_clk);
    rdat = 32'(o_receive_clock_out);
    repeat (4) @(negedge i_clk);
    chk(rdat ^ 32'h1, 32'(o_receive_clock_out));
    rchk(8'h0c, 32'h1, 32'h1);
    xfer(1'b1, 8'h00, 32'h24);
    repeat (12800) @(posedge i_clk);
    chk(32'h0, 32'(o_receive_data_out));
    rchk(8'h0c, 32'h1, 32'h0);
    xfer(1'b1, 8'h00, 32'h31);
    repeat (8240) @(posedge i_clk);
    rchk(8'h0c, 32'h1, 32'h1);
    $display("test alarm done");
    xfer(1'b1, 8'h18, 32'h1);
    xfer(1'b1, 8'h14, 32'h1);
    xfer(1'b1, 8'h08, 32'h08);
    xfer(1'b1, 8'h00, 32'h2a);
    repeat (1600) @(posedge i_clk);
    rchk(8'h0c, 32'h2, 32'h2);
    rchk(8'h1c, 32'hffff, 32'h0);
    rchk(8'h10, 32'h1, 32'h1);
    chk(32'h1, 32'(o_irq));
    xfer(1'b1, 8'h10, 32'h1);
    chk(32'h0, 32'(o_irq));
    xfer(1'b1, 8'h00, 32'h2c);
    repeat (800) @(posedge i_clk);
    rchk(8'h0c, 32'h2, 32'h0);
    rchk(8'h10, 32'h1, 32'h1);
    rchk(8'h1c, 32'hfffe, 32'h4);
    $display("test sequence done");
    xfer(1'b1, 8'h08, 32'h12);
    xfer(1'b1, 8'h00, 32'h21);
    repeat (80) @(posedge i_clk);
    xfer(1'b1, 8'h00, 32'h24);
    repeat (400) @(posedge i_clk);
    xfer(1'b1, 8'h08, 32'h02);
    xfer(1'b1, 8'h08, 32'h12);
    rchk(8'h1c, 32'hffff, 32'h1);
    xfer(1'b1, 8'h04, 32'h14);
    repeat (40) @(negedge i_clk);
    chk(32'h1, 32'(o_line_transmit_pos | o_line_transmit_neg));
    @(posedge i_clk);
    hold_pol <= 1'b1;
    repeat (40) @(negedge i_clk);
    chk(32'h1, 32'(o_violation_pulse_out));
    @(posedge i_clk);
    hold_pol <= 1'b0;
    repeat (40) @(negedge i_clk);
    chk(32'h0, 32'(o_violation_pulse_out));
    $display("test errors done");
    test_done(0);
  end
endmodule
